// ===== acf_pkg.sv
// constants and types shared by both ends of the sample buffer link
package acf_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MOTION_THR = 8'h24;
	localparam logic [7:0] ADDR_STILL_THR = 8'h25;
	localparam logic [7:0] ADDR_STILL_DUR = 8'h26;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h2e;
	localparam logic [7:0] ADDR_IRQ_PINSEL = 8'h2f;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h30;
	localparam logic [7:0] ADDR_FORMAT = 8'h31;
	localparam logic [7:0] ADDR_AXIS_FIRST = 8'h32;
	localparam logic [7:0] ADDR_AXIS_LAST = 8'h37;
	localparam logic [7:0] ADDR_BUF_CTL = 8'h38;
	localparam logic [7:0] ADDR_BUF_STATUS = 8'h39;
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int FLAG_READY = 7;
	localparam int FLAG_ACT = 4;
	localparam int FLAG_STILL = 3;
	localparam int FLAG_WMARK = 1;
	localparam int FLAG_OVR = 0;
	localparam int FMT_INVERT = 5;
	localparam int CTL_MODE_LO = 6;
	localparam int CTL_TRIG_PIN = 5;
	localparam int CTL_SAMPLES_W = 5;
	localparam int STATUS_TRIGGERED = 7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int MAG_SHIFT = 4;
	// ----------------------------------------------------------------
	// buffer shape and timing
	// ----------------------------------------------------------------
	localparam int SAMPLE_W = 48;
	localparam int BUF_DEPTH = 32;
	localparam int CLK_MHZ = 100;
	localparam int CLK_HZ = 100000000;
	localparam int POP_GAP_US = 5;
	localparam int POP_GAP_CYCLES = POP_GAP_US * CLK_MHZ;
	typedef enum logic [1:0] {
		ACF_BYPASS, ACF_FIFO, ACF_STREAM, ACF_TRIGGER
	} acf_mode_type;
endpackage

// ===== acf_link_if.sv
// register link and interrupt pins between host and sensor
`timescale 1ns/10ps
interface acf_link_if;
	logic sel;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	logic interrupt_out_a;
	logic interrupt_out_b;
	modport dev(input sel, req, we, addr, wdata,
		output rdata, ack, interrupt_out_a, interrupt_out_b);
	modport host(output sel, req, we, addr, wdata,
		input rdata, ack, interrupt_out_a, interrupt_out_b);
endinterface

// ===== acf_device.sv
// sensor end: sample buffer, event flags, interrupt routing, registers
// Summary of operation
// - pins active high; invert bit makes low
// - mask enables source; pin-select picks A or B
// - host configures functions before enabling interrupts
// - host disables, reconfigures, then re-enables interrupt
// - flags latch, watermark follows count; data reads or flag read clear
// - sample flag high while unread data exists
// - activity when magnitude exceeds motion threshold
// - stillness below threshold longer than duration
// - watermark while count at or above samples
// - overrun on overwrite or full; clears on read
// - 32-entry xyz buffer with four modes
// - bypass keeps only the latest sample in the axis registers, buffer stays empty
// - fifo mode fills to 32 then stops
// - stream mode drops oldest when full
// - trigger keeps last n then acts fifo
// - host waits 5 us after trigger
// - one trigger until bypass then trigger rearms
// - buffered modes pop oldest into axis registers
// - any data read pops whole entry
// - host leaves 5 us after data reads
// - host drops select between buffer reads
`timescale 1ns/10ps

// --------------------------------------------------------------------
// sample buffer
// --------------------------------------------------------------------
module acf_sample_fifo #(
	parameter int WIDTH = acf_pkg::SAMPLE_W,
	parameter int DEPTH = acf_pkg::BUF_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic flush,
	input wire logic drop,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
	} acf_fifo_type;
	acf_fifo_type s, next_s;
	logic take;
	logic put;

	function automatic logic [AW-1:0] acf_wrap(input logic [AW-1:0] p);
		acf_wrap = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign out_valid = s.cnt != '0;
	assign out_data = s.mem[s.rd];
	assign count = s.cnt;
	// a drop frees the head slot, so a full buffer may still accept
	assign take = out_valid & ((out_ready & !flush) | drop);
	assign in_ready = !flush & ((s.cnt != (AW+1)'(DEPTH)) | take);
	assign put = in_valid & in_ready;

	always_comb begin
		next_s = s;
		if (flush) begin
			next_s.rd = '0;
			next_s.wr = '0;
			next_s.cnt = '0;
		end else begin
			if (put) begin
				next_s.mem[s.wr] = in_data;
				next_s.wr = acf_wrap(s.wr);
			end
			if (take) begin
				next_s.rd = acf_wrap(s.rd);
			end
			next_s.cnt = s.cnt + (AW+1)'(put) - (AW+1)'(take);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// --------------------------------------------------------------------
// device end
// --------------------------------------------------------------------
module acf_device #(
	parameter int DEPTH = acf_pkg::BUF_DEPTH,
	parameter int TICKS_PER_SEC = acf_pkg::CLK_HZ
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// measurement source
	input wire logic sample_valid,
	input wire logic [15:0] sample_x,
	input wire logic [15:0] sample_y,
	input wire logic [15:0] sample_z,
	// host link
	acf_link_if.dev link
);
	localparam int CW = $clog2(DEPTH) + 1;
	typedef struct packed {
		logic [7:0] motion_thr;
		logic [7:0] still_thr;
		logic [7:0] still_dur;
		logic [7:0] mask;
		logic [7:0] pinsel;
		logic [7:0] fmt;
		logic [7:0] ctl;
		logic [47:0] axis;
		logic axis_full;
		logic ovr;
		logic act;
		logic still;
		logic quiet;
		logic touched;
		logic triggered;
		logic trimming;
		logic sel_d;
		logic ack;
		logic [7:0] rdata;
		logic irq_a;
		logic irq_b;
		logic [31:0] tick;
		logic [7:0] secs;
	} acf_dev_type;
	acf_dev_type s, next_s;
	acf_pkg::acf_mode_type mode;
	logic [47:0] sample;
	logic [7:0] flags;
	logic [7:0] route;
	logic [7:0] mag;
	logic [CW-1:0] cnt;
	logic [CW-1:0] n_keep;
	logic raw_a, raw_b, rd, wr, pop, full;
	logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_drop;
	logic [47:0] f_out_data;

	function automatic logic [7:0] acf_abs8(input logic [15:0] v);
		logic [15:0] a;
		a = v[15] ? 16'(-v) : v;
		acf_abs8 = a[acf_pkg::MAG_SHIFT +: 8];
	endfunction

	function automatic logic [7:0] acf_max8(input logic [7:0] a,
		input logic [7:0] b);
		acf_max8 = (a > b) ? a : b;
	endfunction

	assign sample = {sample_z, sample_y, sample_x};
	assign link.rdata = s.rdata;
	assign link.ack = s.ack;
	assign link.interrupt_out_a = s.irq_a;
	assign link.interrupt_out_b = s.irq_b;

	acf_sample_fifo #(.WIDTH(48), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.reset(reset),
		.flush(mode == acf_pkg::ACF_BYPASS),
		.drop(f_drop),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(sample),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data),
		.count(cnt)
	);

	always_comb begin
		next_s = s;
		mode = acf_pkg::acf_mode_type'(s.ctl[acf_pkg::CTL_MODE_LO +: 2]);
		n_keep = CW'(s.ctl[acf_pkg::CTL_SAMPLES_W-1:0]);
		full = cnt == CW'(DEPTH);
		mag = acf_max8(acf_abs8(sample_x),
			acf_max8(acf_abs8(sample_y), acf_abs8(sample_z)));
		flags = '0;
		flags[acf_pkg::FLAG_READY] = s.axis_full;
		flags[acf_pkg::FLAG_ACT] = s.act;
		flags[acf_pkg::FLAG_STILL] = s.still;
		flags[acf_pkg::FLAG_WMARK] = cnt >= n_keep;
		flags[acf_pkg::FLAG_OVR] = s.ovr;
		route = flags & s.mask;
		raw_a = |(route & ~s.pinsel);
		raw_b = |(route & s.pinsel);
		rd = link.req & !link.we;
		wr = link.req & link.we;
		next_s.ack = link.req;
		next_s.sel_d = link.sel;
		// a burst ends when select drops or the address walks past data
		pop = s.touched & ((s.sel_d & !link.sel)
			| (rd & (link.addr > acf_pkg::ADDR_AXIS_LAST)));
		// ------------------------------------------------------------
		// register access
		// ------------------------------------------------------------
		if (rd) begin
			next_s.rdata = 8'h00;
			if (link.addr >= acf_pkg::ADDR_AXIS_FIRST
				&& link.addr <= acf_pkg::ADDR_AXIS_LAST) begin
				next_s.rdata = s.axis[{3'(link.addr
					- acf_pkg::ADDR_AXIS_FIRST), 3'b000} +: 8];
				next_s.touched = 1'b1;
			end
			case (link.addr)
				acf_pkg::ADDR_MOTION_THR: next_s.rdata = s.motion_thr;
				acf_pkg::ADDR_STILL_THR: next_s.rdata = s.still_thr;
				acf_pkg::ADDR_STILL_DUR: next_s.rdata = s.still_dur;
				acf_pkg::ADDR_IRQ_MASK: next_s.rdata = s.mask;
				acf_pkg::ADDR_IRQ_PINSEL: next_s.rdata = s.pinsel;
				acf_pkg::ADDR_FORMAT: next_s.rdata = s.fmt;
				acf_pkg::ADDR_BUF_CTL: next_s.rdata = s.ctl;
				acf_pkg::ADDR_BUF_STATUS: begin
					next_s.rdata = 8'(cnt);
					next_s.rdata[acf_pkg::STATUS_TRIGGERED] = s.triggered;
				end
				acf_pkg::ADDR_IRQ_FLAGS: begin
					next_s.rdata = flags;
					next_s.act = 1'b0;
					next_s.still = 1'b0;
				end
				default: begin
				end
			endcase
		end
		if (wr) begin
			case (link.addr)
				acf_pkg::ADDR_MOTION_THR: next_s.motion_thr = link.wdata;
				acf_pkg::ADDR_STILL_THR: next_s.still_thr = link.wdata;
				acf_pkg::ADDR_STILL_DUR: next_s.still_dur = link.wdata;
				acf_pkg::ADDR_IRQ_MASK: next_s.mask = link.wdata;
				acf_pkg::ADDR_IRQ_PINSEL: next_s.pinsel = link.wdata;
				acf_pkg::ADDR_FORMAT: next_s.fmt = link.wdata;
				acf_pkg::ADDR_BUF_CTL: next_s.ctl = link.wdata;
				default: begin
				end
			endcase
		end
		if (pop) begin
			next_s.axis_full = 1'b0;
			next_s.touched = 1'b0;
			next_s.ovr = 1'b0;
		end
		// ------------------------------------------------------------
		// motion detection, running in every buffer mode
		// ------------------------------------------------------------
		next_s.tick = (s.tick == 32'(TICKS_PER_SEC - 1)) ? '0
			: s.tick + 32'h1;
		if (s.tick == 32'(TICKS_PER_SEC - 1) && s.quiet
			&& s.secs != 8'hff) begin
			next_s.secs = s.secs + 8'h01;
		end
		if (sample_valid) begin
			if (mag > s.motion_thr) begin
				next_s.act = 1'b1;
			end
			next_s.quiet = mag < s.still_thr;
			if (!(mag < s.still_thr)) begin
				next_s.secs = '0;
			end
		end
		if (s.quiet && s.secs > s.still_dur) begin
			next_s.still = 1'b1;
		end
		// ------------------------------------------------------------
		// sample path
		// ------------------------------------------------------------
		if (mode == acf_pkg::ACF_BYPASS) begin
			next_s.triggered = 1'b0;
			next_s.trimming = 1'b0;
			if (sample_valid) begin
				if (s.axis_full) begin
					next_s.ovr = 1'b1;
				end
				next_s.axis = sample;
				next_s.axis_full = 1'b1;
			end
		end else if (sample_valid && full) begin
			next_s.ovr = 1'b1;
		end
		// stream, and trigger before its event, make room by dropping
		f_drop = (sample_valid & full & (mode == acf_pkg::ACF_STREAM
			| (mode == acf_pkg::ACF_TRIGGER & !s.triggered)))
			| (s.trimming & (cnt > n_keep));
		// trimming runs one entry a cycle, far inside the host's wait
		if (s.trimming && !(cnt > n_keep)) begin
			next_s.trimming = 1'b0;
		end
		f_in_valid = sample_valid & (mode != acf_pkg::ACF_BYPASS)
			& !s.trimming;
		f_out_ready = (mode != acf_pkg::ACF_BYPASS) & !s.axis_full;
		if (f_out_valid && f_out_ready) begin
			next_s.axis = f_out_data;
			next_s.axis_full = 1'b1;
		end
		if (mode == acf_pkg::ACF_TRIGGER && !s.triggered
			&& (s.ctl[acf_pkg::CTL_TRIG_PIN] ? raw_b : raw_a)) begin
			next_s.triggered = 1'b1;
			next_s.trimming = 1'b1;
		end
		next_s.irq_a = raw_a ^ s.fmt[acf_pkg::FMT_INVERT];
		next_s.irq_b = raw_b ^ s.fmt[acf_pkg::FMT_INVERT];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// ===== acf_host.sv
// host end: paced register access and interrupt pin sampling
`timescale 1ns/10ps
module acf_host #(
	parameter int GAP_CYCLES = acf_pkg::POP_GAP_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_last,
	output logic cmd_ready,
	// answers
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_refused,
	// interrupt levels, active high whatever the pin polarity
	output logic irq_a_level,
	output logic irq_b_level,
	// sensor link
	acf_link_if.host link
);
	typedef enum logic [1:0] {H_IDLE, H_WAIT, H_GAP} acf_hstate_type;
	typedef struct packed {
		acf_hstate_type st;
		logic ready;
		logic sel;
		logic req;
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic last;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic refused;
		logic [7:0] mask;
		logic invert;
		logic touched;
		logic pend;
		logic [15:0] gap;
		logic [2:0] sa;
		logic [2:0] sb;
		logic la;
		logic lb;
	} acf_host_type;
	acf_host_type s, next_s;
	logic is_data, is_cfg, rise;

	assign cmd_ready = s.ready;
	assign rsp_valid = s.rsp_valid;
	assign rsp_data = s.rsp_data;
	assign rsp_refused = s.refused;
	assign irq_a_level = s.la;
	assign irq_b_level = s.lb;
	assign link.sel = s.sel;
	assign link.req = s.req;
	assign link.we = s.we;
	assign link.addr = s.addr;
	assign link.wdata = s.wdata;

	always_comb begin
		next_s = s;
		next_s.req = 1'b0;
		next_s.rsp_valid = 1'b0;
		next_s.refused = 1'b0;
		is_data = cmd_addr >= acf_pkg::ADDR_AXIS_FIRST
			&& cmd_addr <= acf_pkg::ADDR_AXIS_LAST;
		is_cfg = cmd_write && (cmd_addr == acf_pkg::ADDR_MOTION_THR
			|| cmd_addr == acf_pkg::ADDR_STILL_THR
			|| cmd_addr == acf_pkg::ADDR_STILL_DUR
			|| cmd_addr == acf_pkg::ADDR_IRQ_PINSEL);
		// pins pass three flops; a level counts once the last two agree
		next_s.sa = {s.sa[1:0], link.interrupt_out_a};
		next_s.sb = {s.sb[1:0], link.interrupt_out_b};
		if (s.sa[2] == s.sa[1]) begin
			next_s.la = s.sa[2] ^ s.invert;
		end
		if (s.sb[2] == s.sb[1]) begin
			next_s.lb = s.sb[2] ^ s.invert;
		end
		rise = (next_s.la & !s.la) | (next_s.lb & !s.lb);
		if (rise) begin
			next_s.pend = 1'b1;
		end
		unique case (s.st)
			H_IDLE: begin
				if (!s.sel && (s.pend || rise)) begin
					next_s.ready = 1'b0;
					next_s.pend = 1'b0;
					next_s.gap = 16'(GAP_CYCLES - 1);
					next_s.st = H_GAP;
					// a command offered now is answered, never lost
					if (cmd_valid && s.ready) begin
						next_s.rsp_valid = 1'b1;
						next_s.refused = 1'b1;
					end
				end else if (cmd_valid && s.ready) begin
					// threshold, duration and pin-select writes are refused until every enable is cleared
					if ((is_cfg && s.mask != 8'h00)
						|| (s.touched && !is_data)) begin
						next_s.rsp_valid = 1'b1;
						next_s.refused = 1'b1;
					end else begin
						next_s.ready = 1'b0;
						next_s.sel = 1'b1;
						next_s.req = 1'b1;
						next_s.we = cmd_write;
						next_s.addr = cmd_addr;
						next_s.wdata = cmd_wdata;
						next_s.last = cmd_last;
						next_s.touched = s.touched
							| (is_data & !cmd_write);
						if (cmd_write && cmd_addr == acf_pkg::ADDR_IRQ_MASK)
							next_s.mask = cmd_wdata;
						if (cmd_write && cmd_addr == acf_pkg::ADDR_FORMAT)
							next_s.invert = cmd_wdata[acf_pkg::FMT_INVERT];
						next_s.st = H_WAIT;
					end
				end
			end
			H_WAIT: begin
				if (link.ack) begin
					next_s.rsp_valid = 1'b1;
					next_s.rsp_data = s.we ? 8'h00 : link.rdata;
					if (s.last) begin
						next_s.sel = 1'b0;
						if (s.touched || s.pend) begin
							next_s.touched = 1'b0;
							next_s.pend = 1'b0;
							next_s.gap = 16'(GAP_CYCLES - 1);
							next_s.st = H_GAP;
						end else begin
							next_s.ready = 1'b1;
							next_s.st = H_IDLE;
						end
					end else begin
						next_s.ready = 1'b1;
						next_s.st = H_IDLE;
					end
				end
			end
			H_GAP: begin
				if (s.gap == 16'h0000) begin
					next_s.ready = 1'b1;
					next_s.st = H_IDLE;
				end else begin
					next_s.gap = s.gap - 16'h0001;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '{st: H_IDLE, ready: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end
endmodule

// ===== acf_link_sva.sv
// assertion checker for the register link and interrupt pins
`timescale 1ns/10ps
module acf_link_sva (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link
	input wire logic sel,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic interrupt_out_a,
	input wire logic interrupt_out_b
);
	// ----------------------------------------------------------------
	// shadows of writes seen on the link
	// ----------------------------------------------------------------
	logic [7:0] mask_q;
	logic [7:0] pinsel_q;
	logic [7:0] fmt_q;
	logic [7:0] ctl_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mask_q <= 8'h00;
			pinsel_q <= 8'h00;
			fmt_q <= 8'h00;
			ctl_q <= 8'h00;
		end else if (req && we) begin
			if (addr == acf_pkg::ADDR_IRQ_MASK) mask_q <= wdata;
			if (addr == acf_pkg::ADDR_IRQ_PINSEL) pinsel_q <= wdata;
			if (addr == acf_pkg::ADDR_FORMAT) fmt_q <= wdata;
			if (addr == acf_pkg::ADDR_BUF_CTL) ctl_q <= wdata;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_read(logic [7:0] a);
		req && !we && addr == a;
	endsequence
	// pins are registered, so settings must have stood for one cycle
	sequence s_fmt_steady;
		fmt_q == $past(fmt_q);
	endsequence
	AST_ACK_ONE: assert property (req |=> ack)
		else $error("ack missing one cycle after request");
	AST_ACK_CAUSE: assert property (ack |-> $past(req))
		else $error("ack without request");
	AST_UNMAPPED_ZERO: assert property (
		req && !we && (addr < 8'h24 || addr > 8'h39
		|| (addr > 8'h26 && addr < 8'h2e)) |=> ack && rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_MASK_READBACK: assert property (
		s_read(acf_pkg::ADDR_IRQ_MASK) |=> rdata == mask_q)
		else $error("mask readback wrong");
	AST_PINSEL_READBACK: assert property (
		s_read(acf_pkg::ADDR_IRQ_PINSEL) |=> rdata == pinsel_q)
		else $error("pin select readback wrong");
	AST_PIN_IDLE: assert property (
		mask_q == 8'h00 && $past(mask_q) == 8'h00 ##0 s_fmt_steady
		|-> interrupt_out_a == fmt_q[5] && interrupt_out_b == fmt_q[5])
		else $error("pin not at idle level");
	AST_A_QUIET: assert property (
		(mask_q & ~pinsel_q) == 8'h00
		&& $past(mask_q & ~pinsel_q) == 8'h00
		##0 s_fmt_steady |-> interrupt_out_a == fmt_q[5])
		else $error("pin a active with nothing routed");
	AST_B_QUIET: assert property (
		(mask_q & pinsel_q) == 8'h00
		&& $past(mask_q & pinsel_q) == 8'h00
		##0 s_fmt_steady |-> interrupt_out_b == fmt_q[5])
		else $error("pin b active with nothing routed");
	AST_BYPASS_EMPTY: assert property (
		s_read(acf_pkg::ADDR_BUF_STATUS) ##0 ctl_q[7:6] == 2'b00
		&& $past(ctl_q[7:6]) == 2'b00 |=> rdata[5:0] == 6'h00)
		else $error("buffer not empty in bypass");
	AST_STATUS_MAX: assert property (
		s_read(acf_pkg::ADDR_BUF_STATUS) |=> rdata[5:0] <= 6'h20)
		else $error("buffer count above depth");
	AST_WMARK_ZERO: assert property (
		s_read(acf_pkg::ADDR_IRQ_FLAGS) ##0 ctl_q[4:0] == 5'h00
		|=> rdata[acf_pkg::FLAG_WMARK])
		else $error("watermark clear with zero samples");
endmodule

// ===== acf_test.sv
// self-checking bench joining host and sensor ends
`timescale 1ns/10ps
module accel_fifo_interrupt_logic_test;
	logic clk;
	logic reset;
	logic sample_valid;
	logic [15:0] sample_x;
	logic [15:0] sample_y;
	logic [15:0] sample_z;
	logic cmd_valid;
	logic cmd_write;
	logic [7:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic cmd_last;
	logic cmd_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_refused;
	logic irq_a_level;
	logic irq_b_level;
	int errors;
	int samples_checked;
	int seed;
	logic [7:0] got;
	logic refused;
	logic [47:0] ent;
	logic [47:0] smp[$];
	logic [7:0] ra [11] = '{8'h24, 8'h25, 8'h26, 8'h2e, 8'h2f, 8'h31,
		8'h38, 8'h39, 8'h30, 8'h00, 8'h3a};
	logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
	logic [15:0] av [3] = '{16'h0100, 16'h0110, 16'hfef0};
	acf_link_if i_acf_link_if ();
	// short second and gap keep the run brief
	acf_device #(.TICKS_PER_SEC(10)) i_acf_device (.clk(clk),
		.reset(reset), .sample_valid(sample_valid), .sample_x(sample_x),
		.sample_y(sample_y), .sample_z(sample_z), .link(i_acf_link_if));
	acf_host #(.GAP_CYCLES(5)) i_acf_host (.clk(clk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_refused(rsp_refused), .irq_a_level(irq_a_level),
		.irq_b_level(irq_b_level), .link(i_acf_link_if));
	acf_link_sva i_acf_link_sva (.clk(clk), .reset(reset),
		.sel(i_acf_link_if.sel), .req(i_acf_link_if.req),
		.we(i_acf_link_if.we), .addr(i_acf_link_if.addr),
		.wdata(i_acf_link_if.wdata), .rdata(i_acf_link_if.rdata),
		.ack(i_acf_link_if.ack),
		.interrupt_out_a(i_acf_link_if.interrupt_out_a),
		.interrupt_out_b(i_acf_link_if.interrupt_out_b));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [47:0] seen,
		input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// activity from the magnitude rule: max of |axis|, bits 11:4
	function automatic logic exp_act(input logic [15:0] val,
		input logic [7:0] thr);
		logic [15:0] a;
		a = val[15] ? 16'(-val) : val;
		return a[acf_pkg::MAG_SHIFT +: 8] > thr;
	endfunction
	// bounded wait at falling edges, so flops have settled
	task automatic wait_for(input bit rsp);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((rsp ? rsp_valid : cmd_ready) !== 1'b1 && n < 2000);
		if ((rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
			errors++;
			tally_and_finish();
		end
	endtask
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic l);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_last <= l;
		wait_for(1'b0);
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_for(1'b1);
		got = rsp_data;
		refused = rsp_refused;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		access(1'b1, a, d, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input logic l);
		access(1'b0, a, 8'h00, l);
	endtask
	// whole entry in one burst, select dropped after the last byte
	task automatic rd_entry();
		for (int i = 0; i < 6; i++) begin
			rd(acf_pkg::ADDR_AXIS_FIRST + 8'(i), i == 5);
			ent[8*i +: 8] = got;
		end
	endtask
	// fixed samples put val on x only, others random on every axis
	task automatic push(input int n, input bit fixed, input logic [15:0] val);
		logic [47:0] v;
		for (int i = 0; i < n; i++) begin
			v = 48'({$random(seed), $random(seed)});
			if (fixed) v = {32'h0, val};
			smp.push_back(v);
			@(posedge clk);
			sample_valid <= 1'b1;
			sample_x <= v[15:0];
			sample_y <= v[31:16];
			sample_z <= v[47:32];
		end
		@(posedge clk);
		sample_valid <= 1'b0;
		// long enough for a pin change to pass the host's synchroniser
		repeat (8) @(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		tally_and_finish();
	end
	initial begin
		logic [31:0] v;
		seed = 12764;
		errors = 0;
		samples_checked = 0;
		reset = 1'b1;
		sample_valid = 1'b0;
		sample_x = 16'h0000;
		sample_y = 16'h0000;
		sample_z = 16'h0000;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 8'h00;
		cmd_wdata = 8'h00;
		cmd_last = 1'b0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		check("pin a reset", i_acf_link_if.interrupt_out_a, 48'h0);
		for (int i = 0; i < 11; i++) begin
			rd(ra[i], 1'b1);
			check("reset value", got, rv[i]);
		end
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(ra[(i == 3) ? 4 : i], v[7:0]);
			rd(ra[(i == 3) ? 4 : i], 1'b1);
			check("readback", got, v[7:0]);
		end
		// fifo mode fills and stops, oldest comes out first
		wr(8'h38, 8'h44);
		smp.delete();
		push(40, 1'b0, 16'h0000);
		rd(8'h39, 1'b1);
		check("fifo count", got[5:0], 6'h20);
		rd(8'h30, 1'b1);
		check("fifo flags", got & 8'h03, 8'h03);
		rd_entry();
		check("first entry", ent, smp[0]);
		rd(8'h32, 1'b1);
		check("single byte", got, smp[1][7:0]);
		rd_entry();
		check("after single", ent, smp[2]);
		rd(8'h30, 1'b1);
		check("overrun cleared", got[0], 1'b0);
		// bypass empties, stream fills to the depth
		wr(8'h38, 8'h00);
		rd(8'h39, 1'b1);
		check("bypass count", got[5:0], 6'h00);
		wr(8'h38, 8'h80);
		push(40, 1'b0, 16'h0000);
		rd(8'h39, 1'b1);
		check("stream count", got[5:0], 6'h20);
		// routing: configure first, then enable
		wr(8'h38, 8'h00);
		wr(8'h24, 8'h10);
		wr(8'h2f, 8'h00);
		// stale entry out first, so the pin starts idle
		rd_entry();
		wr(8'h2e, 8'h80);
		push(1, 1'b1, 16'h0005);
		check("irq a ready", {irq_a_level, irq_b_level}, 2'b10);
		rd_entry();
		check("bypass data", ent, smp[$]);
		repeat (8) @(posedge clk);
		check("irq a cleared", irq_a_level, 1'b0);
		wr(8'h24, 8'h11);
		check("enabled reconfig", refused, 1'b1);
		wr(8'h2e, 8'h00);
		wr(8'h2f, 8'h80);
		wr(8'h2e, 8'h80);
		push(1, 1'b1, 16'h0005);
		check("irq b ready", {irq_a_level, irq_b_level}, 2'b01);
		rd_entry();
		wr(8'h2e, 8'h00);
		wr(8'h31, 8'h20);
		repeat (8) @(posedge clk);
		check("inverted pins", {i_acf_link_if.interrupt_out_a,
			i_acf_link_if.interrupt_out_b}, 2'b11);
		check("inverted level", irq_a_level, 1'b0);
		wr(8'h31, 8'h00);
		// activity threshold edge and sign, cleared by a flag read
		for (int i = 0; i < 3; i++) begin
			rd(8'h30, 1'b1);
			push(1, 1'b1, av[i]);
			rd(8'h30, 1'b1);
			check("activity", got[4], exp_act(av[i], 8'h10));
			rd(8'h30, 1'b1);
			check("activity cleared", got[4], 1'b0);
		end
		// stillness needs more than the duration in whole seconds
		wr(8'h25, 8'h20);
		wr(8'h26, 8'h01);
		push(1, 1'b1, 16'h0800);
		// clear stillness latched under the older settings
		rd(8'h30, 1'b1);
		push(1, 1'b1, 16'h0010);
		rd(8'h30, 1'b1);
		check("still early", got[3], 1'b0);
		repeat (40) @(posedge clk);
		rd(8'h30, 1'b1);
		check("still late", got[3], 1'b1);
		// trigger on activity routed to pin a
		wr(8'h38, 8'hc4);
		push(10, 1'b1, 16'h0010);
		wr(8'h2e, 8'h10);
		push(1, 1'b1, 16'h0400);
		repeat (20) @(posedge clk);
		rd(8'h39, 1'b1);
		check("triggered", got[7], 1'b1);
		check("kept entries", got[5:0], 6'h04);
		wr(8'h2e, 8'h00);
		tally_and_finish();
	end
endmodule
